/* File: rtl/summation_shifter_accumulator.sv */
// Behaviour
// - Shift code n shifts the accumulator right by n+1 places, 1 up to 8.
// - The accumulator is 32 bits and byte register 0 carries bits 7 to 0.
// - Byte register 1 carries bits 15 to 8 for reads and writes.
// - Byte register 2 carries bits 23 to 16 for reads and writes.
// - Byte register 3 carries bits 31 to 24, the sign and top bits.
// - In add and subtract modes a write of byte register 0 applies the staged word to the sum, so it goes last.
// - A read of byte register 0 clears the pending summation-complete interrupt.
// - Control zero clears, 10h adds, 20h subtracts, modes shift, sum, sum then shift.
// - Converter summation takes 2 to 256 results by count code, then interrupts.
// - Bipolar converter results are sign-extended into the accumulator.
// - A sticky range error flag sets on overflow and clears only by writing 0.
//
// Local design decision: the APB interface to the registers.
`include "ssa_defines.svh"
`default_nettype none
module summation_shifter_accumulator (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire ssa_pkg::paddr_t i_paddr,
    input wire ssa_pkg::word_t i_pwdata,
    input wire logic i_conv_valid,
    input wire ssa_pkg::conv_t i_conv_data,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq
);
    import ssa_pkg::*;

    function automatic paddr_t addr_of(input logic [7:0] idx);
        addr_of = {2'h0, idx, 2'h0};
    endfunction

    function automatic logic [8:0] sum_target(input logic [2:0] code);
        sum_target = 9'h002 << code;
    endfunction

    // Returns {range error, result}
    function automatic logic [32:0] add_chk(input word_t a, input word_t b,
                                            input logic sub, input logic bip);
        logic [32:0] s;
        s = 33'h0;
        if (bip) begin
            s = sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
            add_chk = {s[32] ^ s[31], s[31:0]};
        end else begin
            s = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
            add_chk = s;
        end
    endfunction

    function automatic word_t shift_acc(input word_t a, input logic [2:0] code,
                                        input logic bip);
        logic [3:0] n;
        n = {1'b0, code} + 4'h1;
        shift_acc = bip ? word_t'($signed(a) >>> n) : (a >> n);
    endfunction

    logic rst_meta, rst_n;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    engine_e state, next_state;
    logic [7:0] ctrl, next_ctrl;
    logic result_polarity, next_pol;
    logic range_err, next_range_err;
    word_t acc, next_acc;
    conv_t stage, next_stage;
    logic [8:0] cnt, next_cnt;
    logic [1:0] int_stat, next_int_stat;
    logic [1:0] int_mask, next_int_mask;
    word_t next_prdata;
    logic next_pready, next_pslverr;

    logic setup, acc_done, wr, rd, mapped, bip, add_mode, ev_done, ev_range;
    logic [1:0] mode;
    logic [32:0] res;
    word_t conv_ext;

    assign setup = i_psel && !i_penable;
    assign acc_done = i_psel && i_penable && o_pready;
    assign wr = acc_done && i_pwrite;
    assign rd = acc_done && !i_pwrite;
    assign bip = !result_polarity;
    assign mode = ctrl[`SSA_MODE_HI:`SSA_MODE_LO];
    assign add_mode = (ctrl == `SSA_CTRL_ADD) || (ctrl == `SSA_CTRL_SUB);
    assign conv_ext = bip ? {{8{i_conv_data[23]}}, i_conv_data} : {8'h00, i_conv_data};

    always_comb begin
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        case (i_paddr)
            addr_of(`SSA_IDX_B0): next_prdata = {24'h00_0000, acc[7:0]};
            addr_of(`SSA_IDX_B1): next_prdata = {24'h00_0000, acc[15:8]};
            addr_of(`SSA_IDX_B2): next_prdata = {24'h00_0000, acc[23:16]};
            addr_of(`SSA_IDX_B3): next_prdata = {24'h00_0000, acc[31:24]};
            addr_of(`SSA_IDX_CTRL): next_prdata = {24'h00_0000, ctrl};
            addr_of(`SSA_IDX_POL): next_prdata = {24'h00_0000, range_err, result_polarity, 6'h00};
            addr_of(`SSA_IDX_ISTAT): next_prdata = {30'h0000_0000, int_stat};
            addr_of(`SSA_IDX_IMASK): next_prdata = {30'h0000_0000, int_mask};
            default: mapped = 1'b0;
        endcase
        // Answer in the first access cycle; zero wait states
        next_pready = setup;
        next_pslverr = setup && !mapped;
        if (!setup) begin
            next_prdata = o_prdata;
        end
    end

    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_pol = result_polarity;
        next_acc = acc;
        next_stage = stage;
        next_cnt = cnt;
        next_int_mask = int_mask;
        ev_done = 1'b0;
        ev_range = 1'b0;
        res = 33'h0_0000_0000;
        if (wr) begin
            case (i_paddr)
                addr_of(`SSA_IDX_CTRL): begin
                    next_ctrl = i_pwdata[7:0];
                    next_cnt = 9'h000;
                    if (i_pwdata[7:0] == `SSA_CTRL_CLEAR) begin
                        next_acc = `SSA_RST_ACC;
                        next_state = ST_IDLE;
                    end else if (i_pwdata[7:6] == `SSA_MODE_SHIFT) begin
                        next_state = ST_SHIFT;
                    end else if (i_pwdata[6]) begin
                        next_state = ST_SUM;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                addr_of(`SSA_IDX_POL): next_pol = i_pwdata[`SSA_POL_POL_BIT];
                addr_of(`SSA_IDX_IMASK): next_int_mask = i_pwdata[1:0];
                addr_of(`SSA_IDX_B0): begin
                    if (add_mode && state == ST_IDLE) begin
                        res = add_chk(acc, {stage, i_pwdata[7:0]},
                                      ctrl == `SSA_CTRL_SUB, bip);
                        next_acc = res[31:0];
                        ev_range = res[32];
                    end else if (state == ST_IDLE) begin
                        next_acc[7:0] = i_pwdata[7:0];
                    end
                end
                addr_of(`SSA_IDX_B1): begin
                    next_stage[7:0] = i_pwdata[7:0];
                    if (!add_mode && state == ST_IDLE) next_acc[15:8] = i_pwdata[7:0];
                end
                addr_of(`SSA_IDX_B2): begin
                    next_stage[15:8] = i_pwdata[7:0];
                    if (!add_mode && state == ST_IDLE) next_acc[23:16] = i_pwdata[7:0];
                end
                addr_of(`SSA_IDX_B3): begin
                    next_stage[23:16] = i_pwdata[7:0];
                    if (!add_mode && state == ST_IDLE) next_acc[31:24] = i_pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        // Engine beats byte writes so a sum is never torn; a control write restarts it
        case ((wr && i_paddr == addr_of(`SSA_IDX_CTRL)) ? ST_IDLE : state)
            ST_SUM: begin
                if (i_conv_valid) begin
                    res = add_chk(acc, conv_ext, 1'b0, bip);
                    next_acc = res[31:0];
                    ev_range = res[32];
                    next_cnt = cnt + 9'h001;
                    if (next_cnt == sum_target(ctrl[`SSA_CNT_HI:`SSA_CNT_LO])) begin
                        ev_done = 1'b1;
                        next_cnt = 9'h000;
                        next_state = (mode == `SSA_MODE_SUMSHIFT) ? ST_SHIFT : ST_IDLE;
                    end
                end
            end
            ST_SHIFT: begin
                next_acc = shift_acc(acc, ctrl[`SSA_SHF_HI:`SSA_SHF_LO], bip);
                next_state = ST_IDLE;
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        next_range_err = range_err;
        next_int_stat = int_stat;
        if (wr && i_paddr == addr_of(`SSA_IDX_POL) && !i_pwdata[`SSA_POL_RANGE_BIT]) begin
            next_range_err = 1'b0;
        end
        if (wr && i_paddr == addr_of(`SSA_IDX_ISTAT)) begin
            next_int_stat = int_stat & ~i_pwdata[1:0];
        end
        if (rd && i_paddr == addr_of(`SSA_IDX_B0)) begin
            next_int_stat[`SSA_INT_DONE] = 1'b0;
        end
        if (ev_range) begin
            next_range_err = 1'b1;
            next_int_stat[`SSA_INT_RANGE] = 1'b1;
        end
        if (ev_done) begin
            next_int_stat[`SSA_INT_DONE] = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            ctrl <= `SSA_RST_BYTE;
            result_polarity <= 1'b0;
            range_err <= 1'b0;
            acc <= `SSA_RST_ACC;
            stage <= 24'h00_0000;
            cnt <= 9'h000;
            int_stat <= 2'h0;
            int_mask <= 2'h0;
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            result_polarity <= next_pol;
            range_err <= next_range_err;
            acc <= next_acc;
            stage <= next_stage;
            cnt <= next_cnt;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            o_prdata <= next_prdata;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
            o_irq <= |(next_int_stat & next_int_mask);
        end
    end

    property p_shift_logical;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (state == ST_SHIFT && result_polarity) |=>
            acc == ($past(acc) >> ({1'b0, $past(ctrl[2:0])} + 4'h1));
    endproperty
    a_shift_logical: assert property (p_shift_logical)
        else $error("logical shift amount wrong");

    property p_shift_arith;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (state == ST_SHIFT && !result_polarity) |=>
            $signed(acc) == ($signed($past(acc)) >>> ({1'b0, $past(ctrl[2:0])} + 4'h1));
    endproperty
    a_shift_arith: assert property (p_shift_arith)
        else $error("arithmetic shift wrong");

    property p_read_b0;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (setup && i_paddr == addr_of(`SSA_IDX_B0)) |=>
            o_pready && o_prdata == {24'h00_0000, $past(acc[7:0])};
    endproperty
    a_read_b0: assert property (p_read_b0)
        else $error("byte 0 read data wrong");

    property p_read_b1;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (setup && i_paddr == addr_of(`SSA_IDX_B1)) |=> o_prdata[7:0] == $past(acc[15:8]);
    endproperty
    a_read_b1: assert property (p_read_b1)
        else $error("byte 1 read data wrong");

    property p_read_b2;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (setup && i_paddr == addr_of(`SSA_IDX_B2)) |=> o_prdata[7:0] == $past(acc[23:16]);
    endproperty
    a_read_b2: assert property (p_read_b2)
        else $error("byte 2 read data wrong");

    property p_read_b3;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (setup && i_paddr == addr_of(`SSA_IDX_B3)) |=> o_prdata[7:0] == $past(acc[31:24]);
    endproperty
    a_read_b3: assert property (p_read_b3)
        else $error("byte 3 read data wrong");

    property p_cpu_add;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (wr && i_paddr == addr_of(`SSA_IDX_B0) && ctrl == `SSA_CTRL_ADD && state == ST_IDLE)
            |=> acc == $past(acc) + {$past(stage), $past(i_pwdata[7:0])};
    endproperty
    a_cpu_add: assert property (p_cpu_add)
        else $error("cpu add result wrong");

    property p_done_clear;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (rd && i_paddr == addr_of(`SSA_IDX_B0) && !ev_done) |=> !int_stat[`SSA_INT_DONE];
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("byte 0 read did not clear done");

    property p_clear;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (wr && i_paddr == addr_of(`SSA_IDX_CTRL) && i_pwdata[7:0] == `SSA_CTRL_CLEAR)
            |=> acc == `SSA_RST_ACC ##1 acc == `SSA_RST_ACC || $past(wr);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero accumulator");

    property p_sum_done;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (state == ST_SUM && i_conv_valid && !wr &&
            cnt == sum_target(ctrl[5:3]) - 9'h001)
            |=> int_stat[`SSA_INT_DONE] && cnt == 9'h000 && state != ST_SUM;
    endproperty
    a_sum_done: assert property (p_sum_done)
        else $error("summation did not complete on count");

    property p_sext;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (state == ST_SUM && i_conv_valid && !result_polarity && !wr) |=>
            acc == $past(acc) + {{8{$past(i_conv_data[23])}}, $past(i_conv_data)};
    endproperty
    a_sext: assert property (p_sext)
        else $error("bipolar sample not sign-extended");

    property p_range_sticky;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (range_err && !(wr && i_paddr == addr_of(`SSA_IDX_POL))) |=> range_err;
    endproperty
    a_range_sticky: assert property (p_range_sticky)
        else $error("range flag lost without software clear");

    c_cpu_add: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
        wr && i_paddr == addr_of(`SSA_IDX_B0) && add_mode);
    c_sum_done: cover property (@(posedge i_ref_clk) disable iff (!rst_n) ev_done);
    c_sum_shift: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
        ev_done ##1 state == ST_SHIFT);
    c_irq: cover property (@(posedge i_ref_clk) disable iff (!rst_n) $rose(o_irq));
endmodule // summation_shifter_accumulator
`default_nettype wire

/* File: common/ssa_defines.svh */
`ifndef SSA_DEFINES_SVH
`define SSA_DEFINES_SVH
// Register indices; byte address is four times the index
`define SSA_IDX_POL 8'hDD
`define SSA_IDX_CTRL 8'hE1
`define SSA_IDX_B0 8'hE2
`define SSA_IDX_B1 8'hE3
`define SSA_IDX_B2 8'hE4
`define SSA_IDX_B3 8'hE5
`define SSA_IDX_ISTAT 8'hF8
`define SSA_IDX_IMASK 8'hF9
// Control field positions and codes
`define SSA_MODE_HI 7
`define SSA_MODE_LO 6
`define SSA_CNT_HI 5
`define SSA_CNT_LO 3
`define SSA_SHF_HI 2
`define SSA_SHF_LO 0
`define SSA_CTRL_CLEAR 8'h00
`define SSA_CTRL_ADD 8'h10
`define SSA_CTRL_SUB 8'h20
`define SSA_MODE_SHIFT 2'h2
`define SSA_MODE_SUM 2'h1
`define SSA_MODE_SUMSHIFT 2'h3
// Polarity register bits
`define SSA_POL_RANGE_BIT 7
`define SSA_POL_POL_BIT 6
// Interrupt status bits
`define SSA_INT_DONE 0
`define SSA_INT_RANGE 1
// Reset values
`define SSA_RST_BYTE 8'h00
`define SSA_RST_ACC 32'h0000_0000
`endif

/* File: common/ssa_pkg.sv */
`default_nettype none
package ssa_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SUM, ST_SHIFT} engine_e;
    typedef logic [11:0] paddr_t;
    typedef logic [31:0] word_t;
    typedef logic [23:0] conv_t;
endpackage
`default_nettype wire

/* File: verification/conv_source.sv */
`default_nettype none
module conv_source (
    input wire logic i_clk,
    output logic o_valid,
    output ssa_pkg::conv_t o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    import ssa_pkg::*;

    initial begin
        o_valid = 1'b0;
        o_data = 24'hA5A5A5;
    end

    // One result per sampling edge; held valid so results can go back to back
    task automatic put(input conv_t d);
        o_valid <= 1'b1;
        o_data <= d;
        @(posedge i_clk);
    endtask

    // Idle line keeps toggling so a stale result can never pass for a fresh one
    task automatic idle(input int n);
        o_valid <= 1'b0;
        repeat (n) begin
            o_data <= ~o_data;
            @(posedge i_clk);
        end
    endtask
endmodule // conv_source
`default_nettype wire

/* File: verification/tb.sv */
`include "ssa_defines.svh"
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; \
    if ((got) !== (ex)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, (ex), (got)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ssa_pkg::*;
    logic ref_clk, resetn, psel, penable, pwrite, conv_valid, pready, pslverr, irq;
    paddr_t paddr;
    word_t pwdata, prdata;
    conv_t conv_data, d;
    int fails = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h39A5C314;
    logic [31:0] acc_exp, w, t;
    logic [7:0] rb;
    logic err, result_polarity, msk;
    logic [1:0] mode;
    logic [2:0] c;

    summation_shifter_accumulator summation_shifter_accumulator_inst (
        .i_ref_clk(ref_clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_conv_valid(conv_valid),
        .i_conv_data(conv_data), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_irq(irq));
    conv_source conv_source_inst (.i_clk(ref_clk), .o_valid(conv_valid), .o_data(conv_data));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Code n moves right by n+1; the sign is kept only for bipolar data
    function automatic logic [31:0] exp_shift(input logic [31:0] v, input logic [2:0] code,
                                              input logic uni);
        logic signed [31:0] s;
        s = v;
        if (uni) return v >> (int'(code) + 1);
        return s >>> (int'(code) + 1);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] dat);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= paddr_t'({idx, 2'b00});
        pwdata <= {24'h000000, dat};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        rb = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic chk_acc(input string nm, input logic [31:0] ex);
        logic [31:0] g;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, `SSA_IDX_B0 + 8'(i), 8'h00);
            g[8*i +: 8] = rb;
        end
        `CHK(nm, ex, g)
    endtask

    task automatic add_word(input logic [31:0] v);
        for (int i = 3; i >= 0; i--) apb(1'b1, `SSA_IDX_B0 + 8'(i), v[8*i +: 8]);
    endtask

    task automatic start(input logic [7:0] ctrl);
        apb(1'b1, `SSA_IDX_CTRL, `SSA_CTRL_CLEAR);
        apb(1'b1, `SSA_IDX_CTRL, ctrl);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_acc("reset acc", 32'h0000_0000);
        apb(1'b0, 8'h10, 8'h00);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 8'h00, rb)
        $display("test reset done");
        start(`SSA_CTRL_ADD);
        acc_exp = 32'h0000_0000;
        for (int k = 0; k < 6; k++) begin
            t = rnd();
            w = {{4{t[27]}}, t[27:0]};
            if (k == 3) apb(1'b1, `SSA_IDX_CTRL, `SSA_CTRL_SUB);
            add_word(w);
            acc_exp = (k >= 3) ? acc_exp - w : acc_exp + w;
            chk_acc("add sub", acc_exp);
        end
        // Outside add and subtract modes the byte writes load the accumulator directly
        apb(1'b1, `SSA_IDX_CTRL, 8'h08);
        w = rnd();
        add_word(w);
        chk_acc("byte load", w);
        $display("test addsub done");
        start(`SSA_CTRL_ADD);
        add_word(32'h7FFF_FFFF);
        add_word(32'h0000_0001);
        apb(1'b0, `SSA_IDX_POL, 8'h00);
        `CHK("range set", 1'b1, rb[`SSA_POL_RANGE_BIT])
        apb(1'b1, `SSA_IDX_POL, 8'h80);
        apb(1'b0, `SSA_IDX_POL, 8'h00);
        `CHK("range sticky", 1'b1, rb[`SSA_POL_RANGE_BIT])
        apb(1'b1, `SSA_IDX_POL, 8'h00);
        apb(1'b0, `SSA_IDX_POL, 8'h00);
        `CHK("range clear", 8'h00, rb)
        apb(1'b1, `SSA_IDX_ISTAT, 8'h03);
        apb(1'b0, `SSA_IDX_ISTAT, 8'h00);
        `CHK("status w1c", 8'h00, rb)
        $display("test range done");
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, `SSA_IDX_POL, p[0] ? 8'h40 : 8'h00);
            for (int n = 0; n < 8; n++) begin
                w = rnd() | (p[0] ? 32'h0 : 32'h8000_0000);
                start(`SSA_CTRL_ADD);
                add_word(w);
                apb(1'b1, `SSA_IDX_CTRL, {`SSA_MODE_SHIFT, 3'b000, 3'(n)});
                acc_exp = exp_shift(w, 3'(n), p[0]);
                chk_acc("shift", acc_exp);
            end
        end
        $display("test shift done");
        for (int j = 0; j < 4; j++) begin
            c = (j == 3) ? 3'd7 : 3'(j);
            result_polarity = j[0];
            msk = (j != 1);
            mode = (j == 2) ? `SSA_MODE_SUMSHIFT : `SSA_MODE_SUM;
            apb(1'b1, `SSA_IDX_POL, result_polarity ? 8'h40 : 8'h00);
            apb(1'b1, `SSA_IDX_ISTAT, 8'h03);
            apb(1'b1, `SSA_IDX_IMASK, {7'h00, msk});
            start({mode, c, 3'(j)});
            acc_exp = 32'h0000_0000;
            for (int i = 0; i < (2 << c); i++) begin
                t = rnd();
                d = t[23:0];
                conv_source_inst.put(d);
                if (t[31]) conv_source_inst.idle(1 + int'(t[30:29]));
                acc_exp += result_polarity ? {8'h00, d} : {{8{d[23]}}, d};
            end
            conv_source_inst.idle(4);
            if (j == 2) acc_exp = exp_shift(acc_exp, 3'd2, 1'b0);
            `CHK("irq raised", msk, irq)
            apb(1'b0, `SSA_IDX_ISTAT, 8'h00);
            `CHK("done status", 1'b1, rb[`SSA_INT_DONE])
            chk_acc("conv sum", acc_exp);
            `CHK("irq cleared", 1'b0, irq)
            apb(1'b0, `SSA_IDX_ISTAT, 8'h00);
            `CHK("done cleared", 1'b0, rb[`SSA_INT_DONE])
        end
        $display("test converter done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
